// File: acgcd_pkg.sv
// Constants, register map and shared decoding for the converter configuration block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers (byte address = 4 x index).
package acgcd_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] ACGCD_IDX_GAIN = 6'h04;
  localparam logic [5:0] ACGCD_IDX_SPARE = 6'h05;
  localparam logic [5:0] ACGCD_IDX_CFG = 6'h06;
  localparam logic [5:0] ACGCD_IDX_TH_UP = 6'h07;
  localparam logic [5:0] ACGCD_IDX_TH_LO = 6'h08;
  localparam logic [5:0] ACGCD_IDX_STATUS = 6'h10;
  localparam logic [5:0] ACGCD_IDX_NONE = 6'h3f;

  // ************************************************************
  // Reset values and writable masks
  // ************************************************************
  localparam logic [15:0] ACGCD_GAIN_RST = 16'h0000;
  localparam logic [15:0] ACGCD_SPARE_RST = 16'h0000;
  localparam logic [15:0] ACGCD_CFG_RST = 16'h0600;
  localparam logic [15:0] ACGCD_TH_UP_RST = 16'h0000;
  localparam logic [7:0] ACGCD_TH_LO_RST = 8'h00;
  localparam logic [15:0] ACGCD_GAIN_MASK = 16'h0777;
  localparam logic [15:0] ACGCD_CFG_MASK = 16'h1fff;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ACGCD_GAIN0_LSB = 0;
  localparam int ACGCD_CHANNEL_GAIN_SELECT_LSB = 4;
  localparam int ACGCD_GAIN2_LSB = 8;
  localparam int ACGCD_CFG_DLY_LSB = 9;
  localparam int ACGCD_CFG_CHOP_BIT = 8;
  localparam int ACGCD_CFG_ALLCH_BIT = 7;
  localparam int ACGCD_CFG_NUM_LSB = 4;
  localparam int ACGCD_CFG_LEN_LSB = 1;
  localparam int ACGCD_CFG_EN_BIT = 0;
  localparam int ACGCD_TH_LO_LSB = 8;
  localparam int ACGCD_STAT_DET_BIT = 0;
  localparam int ACGCD_STAT_SETTLE_BIT = 1;

  // Window length in conversion periods for each length code.
  function automatic logic [11:0] acgcd_window_len(input logic [2:0] code);
    logic [11:0] len;
    len = 12'd128;
    unique case (code)
      3'h0: len = 12'd128;
      3'h1: len = 12'd256;
      3'h2: len = 12'd512;
      3'h3: len = 12'd768;
      3'h4: len = 12'd1280;
      3'h5: len = 12'd1792;
      3'h6: len = 12'd2560;
      3'h7: len = 12'd3584;
    endcase
    return len;
  endfunction

endpackage

// File: acgcd_detect.sv
// Current-detect engine: counts threshold exceedances inside a window of conversions.
// Assumes result strobes and data come from logic on the same clock, one pulse per conversion.
`timescale 1ns/10ps
module acgcd_detect
  import acgcd_pkg::*;
#(
  parameter int ACGCD_RES_W = 24,
  parameter int ACGCD_NCH = 3
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic all_channels_in,
  input wire logic [2:0] trip_code_in,
  input wire logic [2:0] window_code_in,
  input wire logic [ACGCD_NCH-1:0] ch_enable_in,
  input wire logic [ACGCD_RES_W-1:0] threshold_in,
  input wire logic conv_valid_in,
  input wire logic [ACGCD_NCH*ACGCD_RES_W-1:0] results_in,
  output logic detect_pulse_out
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [11:0] win;
    logic [7:0] hits;
    logic pulse;
  } acgcd_det_t;

  acgcd_det_t s_q;
  acgcd_det_t s_d;
  logic [ACGCD_NCH-1:0] exceed;

  // Magnitude of a two's complement result; the most negative code maps to 2^(W-1).
  function automatic logic [ACGCD_RES_W-1:0] acgcd_mag(input logic [ACGCD_RES_W-1:0] v);
    return v[ACGCD_RES_W-1] ? ACGCD_RES_W'(~v + 1'b1) : v;
  endfunction

  // Only enabled channels may exceed, so a disabled channel never trips.
  genvar i;
  generate
    for (i = 0; i < ACGCD_NCH; i++) begin : g_ch
      assign exceed[i] = ch_enable_in[i] &&
        (acgcd_mag(results_in[i*ACGCD_RES_W +: ACGCD_RES_W]) > threshold_in);
    end
  endgenerate

  // ************************************************************
  // Window and exceedance counting
  // ************************************************************
  always_comb begin
    logic trip;
    logic [8:0] hits_next;
    trip = 1'b0;
    hits_next = 9'h000;
    s_d = s_q;
    s_d.pulse = 1'b0;
    // All mode needs every enabled channel over; none enabled never trips.
    trip = all_channels_in ? ((exceed == ch_enable_in) && (|ch_enable_in)) : (|exceed);
    hits_next = {1'b0, s_q.hits} + {8'h00, trip};
    if (!enable_in) begin
      s_d.win = 12'h000;
      s_d.hits = 8'h00;
    end else if (conv_valid_in) begin
      if (trip && (hits_next >= (9'h001 << trip_code_in))) begin
        s_d.pulse = 1'b1;
        s_d.win = 12'h000;
        s_d.hits = 8'h00;
      end else if ((s_q.win + 12'h001) >= acgcd_window_len(window_code_in)) begin
        s_d.win = 12'h000;
        s_d.hits = 8'h00;
      end else begin
        s_d.win = s_q.win + 12'h001;
        s_d.hits = hits_next[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign detect_pulse_out = s_q.pulse;

endmodule

// File: acgcd_top.sv
// Configuration register bank of a three-channel converter: gains, spare word, chop and detect.
// Assumes a single AHB-Lite master, hreadyout fed back as hready, and core strobes on sys_clk_in.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
module acgcd_top
  import acgcd_pkg::*;
#(
  parameter int ACGCD_RES_W = 24
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic mod_clk_en_in,
  input wire logic chop_switch_in,
  input wire logic conv_done_in,
  input wire logic [2:0] ch_enable_in,
  input wire logic [ACGCD_RES_W-1:0] ch0_result_in,
  input wire logic [ACGCD_RES_W-1:0] ch1_result_in,
  input wire logic [ACGCD_RES_W-1:0] ch2_result_in,
  output logic [2:0] ch0_gain_code_out,
  output logic [2:0] ch1_gain_code_out,
  output logic [2:0] ch2_gain_code_out,
  output logic chop_enable_out,
  output logic chop_settling_out,
  output logic detect_mode_enable_out,
  output logic detect_flag_out
);

  // ************************************************************
  // State
  // ************************************************************
  // Every register of the bank, the bus slave's phase state and the chop counter live in
  // one struct, so a single reset branch covers all of it.
  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] spare;
    logic [15:0] cfg;
    logic [15:0] th_up;
    logic [7:0] th_lo;
    logic det_flag;
    logic settling;
    logic [16:0] chop_cnt;
    logic wr_pend;
    logic rd_pend;
    logic [5:0] idx;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } acgcd_regs_t;

  acgcd_regs_t s_q;
  acgcd_regs_t s_d;
  logic det_pulse;
  logic [3:0] dly_code;
  logic [ACGCD_RES_W-1:0] threshold;
  logic taken;
  logic judged;

  // Read word for a register index; unmapped indices read as zero.
  // The lower threshold byte sits in bits 15:8, and the settling bit of status is read only.
  function automatic logic [31:0] acgcd_read(input acgcd_regs_t s, input logic [5:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      ACGCD_IDX_GAIN: v = {16'h0000, s.gain};
      ACGCD_IDX_SPARE: v = {16'h0000, s.spare};
      ACGCD_IDX_CFG: v = {16'h0000, s.cfg};
      ACGCD_IDX_TH_UP: v = {16'h0000, s.th_up};
      ACGCD_IDX_TH_LO: v = {16'h0000, s.th_lo, 8'h00};
      ACGCD_IDX_STATUS: v = 32'({s.settling, s.det_flag});
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign dly_code = s_q.cfg[ACGCD_CFG_DLY_LSB +: 4];
  // The full threshold is the upper word followed by the lower byte.
  assign threshold = ACGCD_RES_W'({s_q.th_up, s_q.th_lo});

  // Address phase decode; BUSY has bit 1 of htrans clear, so it is never taken.
  assign taken = hsel_in && htrans_in[1] && hready_in;

  // Conversions that arrive while chop is still settling are not judged.
  assign judged = conv_done_in && !s_q.settling;

  // ************************************************************
  // Bus slave, chop settling and detect flag
  // ************************************************************
  // Seen from the master, a write has an address phase and then a data phase with no wait
  // state; the store lands at the end of the data phase. A read has an address phase, one
  // wait state and then the data phase with hrdata standing. The wait state costs a cycle
  // per read but builds the read word from registered state only, so a write in the data
  // phase just before is always seen.
  // Limitation: hsize is not looked at, so a narrow write stores bits 15:0 like a word.
  // The response is always OKAY, also for unmapped addresses, which read as zero.
  always_comb begin
    logic clr_det;
    clr_det = 1'b0;
    s_d = s_q;
    s_d.resp = 1'b0;

    // Read data phase: one wait state so a write just before is already stored.
    // hrdata then stands until the next read loads it.
    if (s_q.rd_pend) begin
      s_d.rdata = acgcd_read(s_q, s_q.idx);
      s_d.ready = 1'b1;
      s_d.rd_pend = 1'b0;
    end

    // Write data phase: hwdata stands now, so the store happens here.
    // Unmapped indices are ignored, and a status write only acts on the flag clear bit.
    if (s_q.wr_pend && hready_in) begin
      s_d.wr_pend = 1'b0;
      unique case (s_q.idx)
        // Reserved gain bits are not stored, so they read back as zero.
        ACGCD_IDX_GAIN: s_d.gain = hwdata_in[15:0] & ACGCD_GAIN_MASK;
        ACGCD_IDX_SPARE: s_d.spare = hwdata_in[15:0];
        ACGCD_IDX_CFG: s_d.cfg = hwdata_in[15:0] & ACGCD_CFG_MASK;
        ACGCD_IDX_TH_UP: s_d.th_up = hwdata_in[15:0];
        ACGCD_IDX_TH_LO: s_d.th_lo = hwdata_in[ACGCD_TH_LO_LSB +: 8];
        ACGCD_IDX_STATUS: clr_det = hwdata_in[ACGCD_STAT_DET_BIT];
        default: clr_det = 1'b0;
      endcase
    end

    // Address phase: only taken while the bus is ready; a new address phase may follow a
    // data phase at once, so transfers run back to back.
    if (hready_in) begin
      s_d.wr_pend = taken && hwrite_in;
      s_d.rd_pend = taken && !hwrite_in;
      // Addresses above the map fold onto no register rather than aliasing.
      s_d.idx = (haddr_in[31:8] == 24'h000000) ? haddr_in[7:2] : ACGCD_IDX_NONE;
      if (taken && !hwrite_in) begin
        s_d.ready = 1'b0;
      end
    end

    // Chop settling counts modulator periods; a new switch restarts the count.
    // The counter is loaded with the full period count, 2 up to 65536, which is why it is
    // 17 bits wide; settling ends on the enable pulse that takes it from one to zero.
    // A switch wins over an enable pulse in the same cycle, so that period is not counted.
    if (!s_q.cfg[ACGCD_CFG_CHOP_BIT]) begin
      s_d.settling = 1'b0;
      s_d.chop_cnt = 17'h00000;
    end else if (chop_switch_in) begin
      s_d.settling = 1'b1;
      s_d.chop_cnt = 17'h00001 << (5'(dly_code) + 5'd1);
    end else if (s_q.settling && mod_clk_en_in) begin
      s_d.chop_cnt = s_q.chop_cnt - 17'h00001;
      if (s_q.chop_cnt == 17'h00001) begin
        s_d.settling = 1'b0;
      end
    end

    // A detection in the clearing cycle survives: the set wins over the clear.
    s_d.det_flag = (s_q.det_flag && !clr_det) || det_pulse;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Reset is synchronous. hreadyout comes out of reset high, so the master may start its
  // first address phase in the cycle right after release.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.gain <= ACGCD_GAIN_RST;
      s_q.spare <= ACGCD_SPARE_RST;
      s_q.cfg <= ACGCD_CFG_RST;
      s_q.th_up <= ACGCD_TH_UP_RST;
      s_q.th_lo <= ACGCD_TH_LO_RST;
      s_q.idx <= ACGCD_IDX_NONE;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Current detect
  // ************************************************************
  // The engine sees the full threshold and only the conversions that are judged; its pulse
  // is registered there and turned into the sticky flag here, one cycle later.
  acgcd_detect #(
    .ACGCD_RES_W(ACGCD_RES_W),
    .ACGCD_NCH(3)
  ) u_detect (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .enable_in(s_q.cfg[ACGCD_CFG_EN_BIT]),
    .all_channels_in(s_q.cfg[ACGCD_CFG_ALLCH_BIT]),
    .trip_code_in(s_q.cfg[ACGCD_CFG_NUM_LSB +: 3]),
    .window_code_in(s_q.cfg[ACGCD_CFG_LEN_LSB +: 3]),
    .ch_enable_in(ch_enable_in),
    .threshold_in(threshold),
    .conv_valid_in(judged),
    .results_in({ch2_result_in, ch1_result_in, ch0_result_in}),
    .detect_pulse_out(det_pulse)
  );

  // ************************************************************
  // Outputs, all taken from registers
  // ************************************************************
  // Plain wires from the state struct, so no output has logic between flop and pin.
  assign hrdata_out = s_q.rdata;
  assign hreadyout_out = s_q.ready;
  assign hresp_out = s_q.resp;
  assign ch0_gain_code_out = s_q.gain[ACGCD_GAIN0_LSB +: 3];
  assign ch1_gain_code_out = s_q.gain[ACGCD_CHANNEL_GAIN_SELECT_LSB +: 3];
  assign ch2_gain_code_out = s_q.gain[ACGCD_GAIN2_LSB +: 3];
  assign chop_enable_out = s_q.cfg[ACGCD_CFG_CHOP_BIT];
  assign chop_settling_out = s_q.settling;
  assign detect_mode_enable_out = s_q.cfg[ACGCD_CFG_EN_BIT];
  assign detect_flag_out = s_q.det_flag;

endmodule

// File: acgcd_top_checker.sv
// Checker for the configuration bank: bus wait, field outputs, reset values, chop, flag.
// Assumes hreadyout is looped back as hready; bound to every acgcd_top instance.
`timescale 1ns/10ps
module acgcd_top_checker (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hreadyout_out,
  input wire logic chop_switch_in,
  input wire logic [2:0] ch0_gain_code_out,
  input wire logic [2:0] ch1_gain_code_out,
  input wire logic [2:0] ch2_gain_code_out,
  input wire logic chop_enable_out,
  input wire logic chop_settling_out,
  input wire logic detect_mode_enable_out,
  input wire logic detect_flag_out
);
  logic tw_q;
  logic [31:0] ta_q;
  logic tk;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // A taken write is kept one cycle so that its data phase can be tied to the outputs.
  assign tk = hsel_in & htrans_in[1] & hready_in;
  always_ff @(posedge sys_clk_in) begin
    tw_q <= tk & hwrite_in;
    ta_q <= haddr_in;
  end
  a_ch2_gain: assert property (tw_q && ta_q == 32'h10 |=>
    ch2_gain_code_out == $past(hwdata_in[10:8])) else $error("ch2 gain not loaded");
  a_ch1_gain: assert property (tw_q && ta_q == 32'h10 |=>
    ch1_gain_code_out == $past(hwdata_in[6:4])) else $error("ch1 gain not loaded");
  a_ch0_gain: assert property (tw_q && ta_q == 32'h10 |=>
    ch0_gain_code_out == $past(hwdata_in[2:0])) else $error("ch0 gain not loaded");
  a_chop_bit: assert property (tw_q && ta_q == 32'h18 |=>
    chop_enable_out == $past(hwdata_in[8])) else $error("chop enable not loaded");
  a_detect_bit: assert property (tw_q && ta_q == 32'h18 |=>
    detect_mode_enable_out == $past(hwdata_in[0])) else $error("detect enable wrong");
  a_reset_values: assert property ($fell(reset_in) |-> !chop_enable_out &&
    !detect_mode_enable_out && !chop_settling_out && ch2_gain_code_out == 3'h0)
    else $error("outputs not at reset values");
  a_read_wait: assert property (tk && !hwrite_in |=>
    !hreadyout_out ##1 hreadyout_out) else $error("read wait state wrong");
  a_settle_start: assert property (chop_enable_out && chop_switch_in |=>
    chop_settling_out) else $error("settling did not start");
  a_flag_sticky: assert property (detect_flag_out && !(tw_q && ta_q == 32'h40) |=>
    detect_flag_out) else $error("detect flag dropped");
endmodule
bind acgcd_top acgcd_top_checker chk_u (.sys_clk_in, .reset_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hready_in, .hwdata_in, .hreadyout_out, .chop_switch_in,
  .ch0_gain_code_out, .ch1_gain_code_out, .ch2_gain_code_out, .chop_enable_out,
  .chop_settling_out, .detect_mode_enable_out, .detect_flag_out);

// File: acgcd_host.sv
// Host model: single whole-word AHB-Lite transfers, each read handed back as a result pulse.
// Assumes the slave's hreadyout returns on hready_in and both sides share one clock.
`timescale 1ns/10ps
module acgcd_host
  import acgcd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out = 1'b0,
  output logic [31:0] haddr_out = 32'h0,
  output logic [1:0] htrans_out = 2'h0,
  output logic hwrite_out = 1'b0,
  output logic [31:0] hwdata_out = 32'h0,
  output logic rvalid_out = 1'b0,
  output logic [31:0] rdata_out = 32'h0
);
  logic rdy_s;
  logic [31:0] rd_s;
  // ************************************************************
  // Bus cycles
  // ************************************************************
  // Slave outputs move only at rising edges, so a falling-edge copy is what the next edge sees.
  always @(negedge sys_clk_in) begin
    rdy_s = hready_in;
    rd_s = hrdata_in;
  end
  // Reserved gain and config bits always go out as zero, and the spare word is only ever written with zero.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    logic [31:0] m;
    m = (a == 32'h10) ? {16'h0, ACGCD_GAIN_MASK} : 32'hffffffff;
    if (a == 32'h18) m = {16'h0, ACGCD_CFG_MASK};
    if (a == 32'h14) m = 32'h0;
    @(posedge sys_clk_in);
    hsel_out <= 1'b1;
    htrans_out <= 2'h2;
    haddr_out <= a;
    hwrite_out <= w;
    do @(posedge sys_clk_in); while (rdy_s !== 1'b1);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= d & m;
    do @(posedge sys_clk_in); while (rdy_s !== 1'b1);
    rvalid_out <= !w;
    rdata_out <= rd_s;
    @(posedge sys_clk_in);
    rvalid_out <= 1'b0;
  endtask
endmodule

// File: adc_gain_chop_detect_config_bench.sv
// Self-checking bench for the configuration bank: map, fields, chop settling, detection.
// Assumes the host model owns the bus; core strobes are driven here on the same clock.
`timescale 1ns/10ps
module adc_gain_chop_detect_config_bench;
  logic clk = 1'b0, rst = 1'b1, mod = 1'b0, sw = 1'b0, conv = 1'b0, rv;
  logic hsel, hwrite, hready, hresp, g_ce, g_cs, g_de, g_df;
  logic [1:0] htrans;
  logic [2:0] chen = 3'h7, g0, g1, g2;
  logic [23:0] r0 = 24'h0, r1 = 24'h0, r2 = 24'h0;
  logic [31:0] haddr, hwdata, hrdata, rd, seed = 32'd73;
  logic [31:0] exp_q[$];
  int failures = 0;
  int n_compared = 0;
  // ************************************************************
  // Clock, parts and helpers
  // ************************************************************
  always #5 clk = ~clk;
  acgcd_host host_u (.sys_clk_in(clk), .hready_in(hready), .hrdata_in(hrdata),
    .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
    .hwdata_out(hwdata), .rvalid_out(rv), .rdata_out(rd));
  acgcd_top dut_u (.sys_clk_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .mod_clk_en_in(mod), .chop_switch_in(sw), .conv_done_in(conv), .ch_enable_in(chen),
    .ch0_result_in(r0), .ch1_result_in(r1), .ch2_result_in(r2), .ch0_gain_code_out(g0),
    .ch1_gain_code_out(g1), .ch2_gain_code_out(g2), .chop_enable_out(g_ce),
    .chop_settling_out(g_cs), .detect_mode_enable_out(g_de), .detect_flag_out(g_df));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rdx(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host_u.xfer(a, 1'b0, 32'h0);
  endtask
  // A strobe is high for exactly one sampled edge, then settled outputs are looked at.
  // k picks the strobe: 0 chop switch, 1 modulator enable, 2 conversion done.
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) sw <= 1'b1;
    else if (k == 1) mod <= 1'b1;
    else conv <= 1'b1;
    @(posedge clk);
    sw <= 1'b0;
    mod <= 1'b0;
    conv <= 1'b0;
    #1;
  endtask
  task automatic cv(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c);
    @(posedge clk);
    r0 <= a;
    r1 <= b;
    r2 <= c;
    pulse(2);
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Each read result is paired with the oldest expectation noted by the driver.
  always @(posedge clk) if (rv === 1'b1) begin
    check("read data", rd, exp_q.pop_front());
    check("response", 32'(hresp), 32'h0);
  end
  initial begin
    #60us;
    failures++;
    complete_run;
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdx(32'h10, 32'h0);
    rdx(32'h14, 32'h0);
    rdx(32'h18, 32'h0600);
    rdx(32'h3c, 32'h0);
    repeat (4) begin
      seed = xs(seed);
      host_u.xfer(32'h10, 1'b1, seed);
      rdx(32'h10, seed & 32'h0777);
      check("ch0 gain", 32'(g0), 32'(seed[2:0]));
      check("ch1 gain", 32'(g1), 32'(seed[6:4]));
      check("ch2 gain", 32'(g2), 32'(seed[10:8]));
      host_u.xfer(32'h18, 1'b1, seed & 32'h1ffe);
      rdx(32'h18, seed & 32'h1ffe);
      check("chop enable", 32'(g_ce), 32'(seed[8]));
    end
    host_u.xfer(32'h14, 1'b1, 32'h0);
    rdx(32'h14, 32'h0);
    for (int c = 0; c < 2; c++) begin
      host_u.xfer(32'h18, 1'b1, 32'h0100 | (32'(c) << 9));
      pulse(0);
      repeat (2 << c) begin
        check("settling", 32'(g_cs), 32'h1);
        pulse(1);
      end
      check("settling end", 32'(g_cs), 32'h0);
    end
    host_u.xfer(32'h1c, 1'b1, 32'h0);
    host_u.xfer(32'h20, 1'b1, 32'h0500);
    host_u.xfer(32'h18, 1'b1, 32'h0011);
    check("detect enable", 32'(g_de), 32'h1);
    cv(24'd5, 24'd0, 24'd0);
    cv(-24'sd6, 24'd0, 24'd0);
    check("flag one trip", 32'(g_df), 32'h0);
    cv(24'd6, 24'd0, 24'd0);
    check("flag two trips", 32'(g_df), 32'h1);
    // Second trip on the last conversion of a 128 window detects; one later it does not.
    for (int n = 126; n < 128; n++) begin
      host_u.xfer(32'h40, 1'b1, 32'h1);
      cv(24'd6, 24'd0, 24'd0);
      repeat (n) cv(24'd0, 24'd0, 24'd0);
      cv(24'd6, 24'd0, 24'd0);
      check("window end", 32'(g_df), 32'(n == 126));
    end
    host_u.xfer(32'h40, 1'b1, 32'h1);
    host_u.xfer(32'h18, 1'b1, 32'h0081);
    cv(24'd9, 24'd0, 24'd9);
    check("flag some", 32'(g_df), 32'h0);
    cv(24'd9, 24'd9, -24'sd9);
    check("flag all", 32'(g_df), 32'h1);
    rdx(32'h40, 32'h1);
    // With channel 2 left out, all mode trips on channels 0 and 1 alone.
    host_u.xfer(32'h40, 1'b1, 32'h1);
    chen <= 3'h3;
    cv(24'd9, 24'd9, 24'd0);
    check("flag enabled only", 32'(g_df), 32'h1);
    complete_run;
  end
endmodule
